// >>> shared/oamr_pkg.sv
// shared constants and types for the operand addressing mode resolver
`default_nettype none
package oamr_pkg;
    // addressing modes handled by this block
    typedef enum logic [2:0] {
        MODE_NONE       = 3'b000,
        MODE_SRC_IDX    = 3'b001,
        MODE_DST_DIR    = 3'b010,
        MODE_DST_IDX    = 3'b011,
        MODE_DST_DIR_IM = 3'b100,
        MODE_DST_IDX_IM = 3'b101,
        MODE_MEM_MOVE   = 3'b110
    } oamr_mode_t;

    // where the result lands
    typedef enum logic [1:0] {
        DST_ACC = 2'b00,
        DST_IDX = 2'b01,
        DST_MEM = 2'b10
    } oamr_dst_t;

    // what feeds either arithmetic input
    typedef enum logic [1:0] {
        SRC_MEM = 2'b00,
        SRC_ACC = 2'b01,
        SRC_IDX = 2'b10,
        SRC_IMM = 2'b11
    } oamr_src_t;

    localparam logic [1:0] LEN_TWO   = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [1:0] LEN_ZERO  = 2'h0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : oamr_pkg
`default_nettype wire

// >>> logic/oamr_addr_gen.sv
// operand address former: direct byte or byte plus index
`timescale 1ns/100ps
`default_nettype none
module oamr_addr_gen #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] operand_byte,  // first operand byte
    input  wire logic [W-1:0] index_val,     // index register content
    input  wire logic         use_index,     // add index when high
    output logic      [W-1:0] addr           // effective address
);
    // sum wraps to W bits; carry out dropped on purpose
    logic [W:0] sum_full;
    assign sum_full = {1'b0, operand_byte} + {1'b0, index_val};
    assign addr     = use_index ? sum_full[W-1:0] : operand_byte;
endmodule : oamr_addr_gen
`default_nettype wire

// >>> logic/oamr_resolver.sv
// operand addressing mode resolver for an 8-bit core
// How it works
// - source-indexed mode reads at operand plus index and writes acc or index, two bytes.
// - source-indexed arithmetic takes its second input from the register the opcode names.
// - direct-destination mode writes the result at the first operand address, two bytes.
// - direct-destination sources acc or index and combines with the destination content.
// - indexed-destination mode writes at operand plus index, two bytes.
// - indexed-destination uses only the accumulator as source and leaves it unchanged.
// - direct-destination immediate uses operand two as source, three bytes.
// - indexed-destination immediate adds index to operand one, operand two is source.
// - indexed-destination arithmetic reads and writes back the same indexed location.
// - memory-to-memory mode is legal only for the move, three bytes, RAM destination.
// - memory-to-memory move reads RAM at operand two and writes RAM at operand one.
// - every indexed mode uses the index register as its offset.
`timescale 1ns/100ps
`default_nettype none
module oamr_resolver #(
    parameter int W = 8
) (
    input  wire logic               clk,          // core clock
    input  wire logic               arst_n,       // async reset, active low
    input  wire logic               dec_valid,    // decoded instruction present
    input  wire oamr_pkg::oamr_mode_t mode_in,    // addressing mode from opcode
    input  wire logic               reg_sel_idx,  // opcode names index register
    input  wire logic               reg_space,    // opcode targets register space
    input  wire logic               is_arith,     // opcode is arithmetic
    input  wire logic               is_move,      // opcode is move_instruction
    input  wire logic [W-1:0]       operand1,     // first operand byte
    input  wire logic [W-1:0]       operand2,     // second operand byte
    input  wire logic [W-1:0]       index_reg,    // index register content
    output logic                    res_valid,    // resolution valid
    output logic                    illegal,      // mode refused for this opcode
    output logic [W-1:0]            src_addr,     // memory read address
    output logic                    src_rd,       // memory read requested
    output logic                    src_reg_space,// read in register space
    output logic [W-1:0]            dst_addr,     // memory write address
    output oamr_pkg::oamr_dst_t     dst_sel,      // result destination
    output logic                    dst_reg_space,// write in register space
    output oamr_pkg::oamr_src_t     alu_a_sel,    // first alu input
    output oamr_pkg::oamr_src_t     alu_b_sel,    // second alu input
    output logic                    alu_b_used,   // second input takes part
    output logic [W-1:0]            imm_val,      // immediate source value
    output logic [1:0]              instr_len     // length in bytes
);
    ////////////////////////////////////////////////////////////////////////
    // address formation
    wire logic         use_idx;
    wire logic [W-1:0] op1_addr;

    assign use_idx = (mode_in == oamr_pkg::MODE_SRC_IDX) ||
                     (mode_in == oamr_pkg::MODE_DST_IDX) ||
                     (mode_in == oamr_pkg::MODE_DST_IDX_IM);

    oamr_addr_gen #(.W(W)) u_addr (
        .operand_byte (operand1),
        .index_val    (index_reg),
        .use_index    (use_idx),
        .addr         (op1_addr)
    );

    wire oamr_pkg::oamr_src_t reg_src;
    wire oamr_pkg::oamr_dst_t reg_dst;
    assign reg_src = reg_sel_idx ? oamr_pkg::SRC_IDX : oamr_pkg::SRC_ACC;
    assign reg_dst = reg_sel_idx ? oamr_pkg::DST_IDX : oamr_pkg::DST_ACC;

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    logic                 ill_next;
    logic [W-1:0]         src_addr_next;
    logic                 src_rd_next;
    logic                 src_rs_next;
    logic [W-1:0]         dst_addr_next;
    oamr_pkg::oamr_dst_t  dst_sel_next;
    logic                 dst_rs_next;
    oamr_pkg::oamr_src_t  a_next;
    oamr_pkg::oamr_src_t  b_next;
    logic                 b_used_next;
    logic [W-1:0]         imm_next;
    logic [1:0]           len_next;

    always_comb begin
        ill_next      = 1'b0;
        src_addr_next = oamr_pkg::RESET_BYTE;
        src_rd_next   = 1'b0;
        src_rs_next   = 1'b0;
        dst_addr_next = oamr_pkg::RESET_BYTE;
        dst_sel_next  = oamr_pkg::DST_ACC;
        dst_rs_next   = 1'b0;
        a_next        = oamr_pkg::SRC_ACC;
        b_next        = oamr_pkg::SRC_ACC;
        b_used_next   = 1'b0;
        imm_next      = oamr_pkg::RESET_BYTE;
        len_next      = oamr_pkg::LEN_ZERO;
        case (mode_in)
            oamr_pkg::MODE_SRC_IDX: begin
                src_addr_next = op1_addr;
                src_rd_next   = 1'b1;
                src_rs_next   = reg_space;
                dst_sel_next  = reg_dst;
                a_next        = oamr_pkg::SRC_MEM;
                b_next        = reg_src;
                b_used_next   = is_arith;
                len_next      = oamr_pkg::LEN_TWO;
            end
            oamr_pkg::MODE_DST_DIR: begin
                dst_addr_next = op1_addr;
                dst_sel_next  = oamr_pkg::DST_MEM;
                dst_rs_next   = reg_space;
                a_next        = reg_src;
                src_addr_next = op1_addr;
                src_rd_next   = is_arith;
                src_rs_next   = reg_space;
                b_next        = oamr_pkg::SRC_MEM;
                b_used_next   = is_arith;
                len_next      = oamr_pkg::LEN_TWO;
            end
            oamr_pkg::MODE_DST_IDX: begin
                dst_addr_next = op1_addr;
                dst_sel_next  = oamr_pkg::DST_MEM;
                dst_rs_next   = reg_space;
                a_next        = oamr_pkg::SRC_ACC;
                src_addr_next = op1_addr;
                src_rd_next   = is_arith;
                src_rs_next   = reg_space;
                b_next        = oamr_pkg::SRC_MEM;
                b_used_next   = is_arith;
                len_next      = oamr_pkg::LEN_TWO;
            end
            oamr_pkg::MODE_DST_DIR_IM: begin
                dst_addr_next = op1_addr;
                dst_sel_next  = oamr_pkg::DST_MEM;
                dst_rs_next   = reg_space;
                a_next        = oamr_pkg::SRC_IMM;
                imm_next      = operand2;
                src_addr_next = op1_addr;
                src_rd_next   = is_arith;
                src_rs_next   = reg_space;
                b_next        = oamr_pkg::SRC_MEM;
                b_used_next   = is_arith;
                len_next      = oamr_pkg::LEN_THREE;
            end
            oamr_pkg::MODE_DST_IDX_IM: begin
                dst_addr_next = op1_addr;
                dst_sel_next  = oamr_pkg::DST_MEM;
                dst_rs_next   = reg_space;
                a_next        = oamr_pkg::SRC_IMM;
                imm_next      = operand2;
                src_addr_next = op1_addr;
                src_rd_next   = is_arith;
                src_rs_next   = reg_space;
                b_next        = oamr_pkg::SRC_MEM;
                b_used_next   = is_arith;
                len_next      = oamr_pkg::LEN_THREE;
            end
            oamr_pkg::MODE_MEM_MOVE: begin
                ill_next      = !is_move;
                src_addr_next = operand2;
                src_rd_next   = is_move;
                src_rs_next   = 1'b0;
                dst_addr_next = operand1;
                dst_sel_next  = oamr_pkg::DST_MEM;
                dst_rs_next   = 1'b0;
                a_next        = oamr_pkg::SRC_MEM;
                len_next      = oamr_pkg::LEN_THREE;
            end
            default: begin
                ill_next      = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs; one cycle after the decode is presented
    wire logic take;
    assign take = dec_valid && (mode_in != oamr_pkg::MODE_NONE);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            res_valid     <= 1'b0;
            illegal       <= 1'b0;
            src_addr      <= oamr_pkg::RESET_BYTE;
            src_rd        <= 1'b0;
            src_reg_space <= 1'b0;
            dst_addr      <= oamr_pkg::RESET_BYTE;
            dst_sel       <= oamr_pkg::DST_ACC;
            dst_reg_space <= 1'b0;
            alu_a_sel     <= oamr_pkg::SRC_ACC;
            alu_b_sel     <= oamr_pkg::SRC_ACC;
            alu_b_used    <= 1'b0;
            imm_val       <= oamr_pkg::RESET_BYTE;
            instr_len     <= oamr_pkg::LEN_ZERO;
        end else begin
            res_valid     <= take && !ill_next;
            illegal       <= take && ill_next;
            src_addr      <= src_addr_next;
            src_rd        <= take && !ill_next && src_rd_next;
            src_reg_space <= src_rs_next;
            dst_addr      <= dst_addr_next;
            dst_sel       <= dst_sel_next;
            dst_reg_space <= dst_rs_next;
            alu_a_sel     <= a_next;
            alu_b_sel     <= b_next;
            alu_b_used    <= b_used_next;
            imm_val       <= imm_next;
            instr_len     <= len_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_idx_src;
        dec_valid && mode_in == oamr_pkg::MODE_SRC_IDX;
    endsequence

    a_src_idx_addr: assert property (
        s_idx_src |=> src_addr == 8'($past(operand1) + $past(index_reg))
                      && instr_len == 2'h2 && src_rd)
        else $error("indexed source address wrong");

    a_src_idx_b: assert property (
        s_idx_src and is_arith |=> alu_b_used && alu_a_sel == oamr_pkg::SRC_MEM
                      && alu_b_sel == ($past(reg_sel_idx) ? oamr_pkg::SRC_IDX
                                                         : oamr_pkg::SRC_ACC))
        else $error("indexed source alu input wrong");

    a_dst_dir_addr: assert property (
        dec_valid && mode_in == oamr_pkg::MODE_DST_DIR |=>
            dst_addr == $past(operand1) && dst_sel == oamr_pkg::DST_MEM && instr_len == 2'h2)
        else $error("direct destination wrong");

    a_dst_dir_src: assert property (
        dec_valid && mode_in == oamr_pkg::MODE_DST_DIR && is_arith |=>
            src_addr == dst_addr && alu_b_sel == oamr_pkg::SRC_MEM && dst_sel == oamr_pkg::DST_MEM
            && src_rd && alu_a_sel == ($past(reg_sel_idx) ? oamr_pkg::SRC_IDX
                                                          : oamr_pkg::SRC_ACC))
        else $error("direct destination operand wrong");

    a_dst_idx_acc: assert property (
        dec_valid && mode_in == oamr_pkg::MODE_DST_IDX |=>
            alu_a_sel == oamr_pkg::SRC_ACC && dst_sel == oamr_pkg::DST_MEM
            && dst_addr == 8'($past(operand1) + $past(index_reg)))
        else $error("indexed destination source wrong");

    a_imm_len: assert property (
        dec_valid && (mode_in == oamr_pkg::MODE_DST_DIR_IM || mode_in == oamr_pkg::MODE_DST_IDX_IM)
        |=> instr_len == 2'h3 && imm_val == $past(operand2) && alu_a_sel == oamr_pkg::SRC_IMM)
        else $error("immediate destination wrong");

    a_idx_imm_addr: assert property (
        dec_valid && mode_in == oamr_pkg::MODE_DST_IDX_IM |=>
            dst_addr == 8'($past(operand1) + $past(index_reg)) && dst_sel == oamr_pkg::DST_MEM
            && imm_val == $past(operand2) && instr_len == 2'h3)
        else $error("indexed destination immediate wrong");

    a_idx_rmw: assert property (
        dec_valid && is_arith && (mode_in == oamr_pkg::MODE_DST_IDX_IM ||
                                  mode_in == oamr_pkg::MODE_DST_IDX)
        |=> src_rd && src_addr == dst_addr)
        else $error("indexed read-modify-write address mismatch");

    a_move_only: assert property (
        dec_valid && mode_in == oamr_pkg::MODE_MEM_MOVE |=>
            illegal == !$past(is_move) && !dst_reg_space && instr_len == 2'h3)
        else $error("memory move legality wrong");

    a_move_addrs: assert property (
        dec_valid && is_move && mode_in == oamr_pkg::MODE_MEM_MOVE |=>
            src_addr == $past(operand2) && dst_addr == $past(operand1) && !src_reg_space)
        else $error("memory move addresses wrong");
endmodule : oamr_resolver
`default_nettype wire

// >>> testbench/tb_operand_address_mode_resolver.sv
// self-checking bench for the operand addressing mode resolver
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_operand_address_mode_resolver;
////////////////////////////////////////////////////////////////////////////////
typedef struct packed {
    logic rv, il, srd, srs, drs, abu, chk_s, chk_d, chk_b, chk_i;
    logic [7:0] sa, da, im;
    logic [1:0] ds, aa, ab, len;
} oamr_exp_t;
logic clk = 1'b0, arst_n = 1'b0, dec_valid = 1'b0;
logic reg_sel_idx = 1'b0, reg_space = 1'b0, is_arith = 1'b0, is_move = 1'b0;
logic [7:0] operand1 = 8'h00, operand2 = 8'h00, index_reg = 8'h00;
oamr_pkg::oamr_mode_t mode_in = oamr_pkg::MODE_NONE;
logic res_valid, illegal, src_rd, src_reg_space, dst_reg_space, alu_b_used;
logic [7:0] src_addr, dst_addr, imm_val;
logic [1:0] instr_len;
oamr_pkg::oamr_dst_t dst_sel;
oamr_pkg::oamr_src_t alu_a_sel, alu_b_sel;
oamr_exp_t q[$];
oamr_exp_t e;
int err_count = 0, n_compared = 0, cycles = 0, seed = 11;
always #5 clk = ~clk;
oamr_resolver #(.W(8)) DUT (.clk(clk), .arst_n(arst_n), .dec_valid(dec_valid),
    .mode_in(mode_in), .reg_sel_idx(reg_sel_idx), .reg_space(reg_space),
    .is_arith(is_arith), .is_move(is_move), .operand1(operand1), .operand2(operand2),
    .index_reg(index_reg), .res_valid(res_valid), .illegal(illegal), .src_addr(src_addr),
    .src_rd(src_rd), .src_reg_space(src_reg_space), .dst_addr(dst_addr), .dst_sel(dst_sel),
    .dst_reg_space(dst_reg_space), .alu_a_sel(alu_a_sel), .alu_b_sel(alu_b_sel),
    .alu_b_used(alu_b_used), .imm_val(imm_val), .instr_len(instr_len));
////////////////////////////////////////////////////////////////////////////////
function automatic oamr_exp_t model(input logic [2:0] m, input logic sel, rs, ar, mv,
                                    input logic [7:0] o1, o2, ix);
    oamr_exp_t x;
    logic [7:0] sum;
    logic [1:0] reg_code;
    x = '0;
    sum = o1 + ix;
    reg_code = sel ? 2'h1 : 2'h0;
    x.rv = !(m == 3'h6 && !mv);
    x.il = !x.rv;
    x.len = (m >= 3'h4) ? 2'h3 : 2'h2;
    x.abu = ar;
    x.drs = rs;
    x.srs = rs;
    x.ds = 2'h2;
    x.chk_d = 1'b1;
    x.chk_b = ar;
    x.ab = 2'h0;
    x.da = (m == 3'h3 || m == 3'h5) ? sum : o1;
    x.chk_s = ar;
    x.srd = ar;
    x.sa = x.da;
    case (m)
        3'h1: begin
            x.sa = sum;
            x.srd = 1'b1;
            x.chk_s = 1'b1;
            x.chk_d = 1'b0;
            x.ds = reg_code;
            x.aa = 2'h0;
            x.ab = sel ? 2'h2 : 2'h1;
        end
        3'h2: x.aa = sel ? 2'h2 : 2'h1;
        3'h3: x.aa = 2'h1;
        3'h4, 3'h5: begin
            x.aa = 2'h3;
            x.im = o2;
            x.chk_i = 1'b1;
        end
        default: begin
            x.sa = o2;
            x.srd = x.rv;
            x.chk_s = 1'b1;
            x.srs = 1'b0;
            x.drs = 1'b0;
            x.chk_d = x.rv;
            x.chk_b = 1'b0;
            x.abu = 1'b0;
        end
    endcase
    return x;
endfunction : model
// inputs change at the falling edge so the rising edge always samples settled values
task automatic drive(input logic [2:0] m, input logic sel, rs, ar, mv,
                     input logic [7:0] o1, o2, ix, input logic v);
    @(negedge clk);
    mode_in = oamr_pkg::oamr_mode_t'(m);
    {reg_sel_idx, reg_space, is_arith, is_move} = {sel, rs, ar, mv};
    {operand1, operand2, index_reg, dec_valid} = {o1, o2, ix, v};
    if (v && m != 3'h0 && arst_n) q.push_back(model(m, sel, rs, ar, mv, o1, o2, ix));
endtask : drive
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    #1;
    if (!arst_n) begin
        `CHK("res_valid", 1'b0, res_valid)
        `CHK("illegal", 1'b0, illegal)
    end else if (res_valid === 1'b1 || illegal === 1'b1 || q.size() != 0) begin
        if (q.size() == 0) begin
            err_count++;
            $display("mismatch result expected none seen %h", {res_valid, illegal});
        end else begin
            e = q.pop_front();
            `CHK("res_valid", e.rv, res_valid)
            `CHK("illegal", e.il, illegal)
            `CHK("instr_len", e.len, instr_len)
            `CHK("src_rd", e.srd, src_rd)
            if (e.chk_s) `CHK("src_addr", e.sa, src_addr)
            if (e.chk_s) `CHK("src_space", e.srs, src_reg_space)
            if (e.chk_d) `CHK("dst_addr", e.da, dst_addr)
            if (e.chk_d) `CHK("dst_space", e.drs, dst_reg_space)
            if (e.rv) `CHK("dst_sel", e.ds, dst_sel)
            if (e.rv && !e.il && e.len != 2'h3 || e.chk_i) `CHK("alu_a", e.aa, alu_a_sel)
            if (e.chk_b) `CHK("alu_b", e.ab, alu_b_sel)
            if (e.rv) `CHK("alu_b_used", e.abu, alu_b_used)
            if (e.chk_i) `CHK("imm_val", e.im, imm_val)
        end
    end
end
always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
        err_count++;
        $display("mismatch timeout expected done seen cycle %0d", cycles);
        results();
    end
end
task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask : results
////////////////////////////////////////////////////////////////////////////////
initial begin
    logic [7:0] r;
    repeat (4) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    drive(3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h07, 8'h00, 8'h03, 1'b1);
    // every mode and opcode flag combination, back to back, with an index wrap
    for (int k = 0; k < 112; k++) begin
        drive(k[6:4], k[3], k[2], k[1], k[0], 8'hf0, 8'h5a, 8'h20 + 8'(k), 1'b1);
    end
    drive(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0);
    $display("test mode sweep done");
    for (int k = 0; k < 300; k++) begin
        r = 8'($random(seed));
        drive(3'(r % 7), r[3], r[4], r[5], r[6], 8'($random(seed)), 8'($random(seed)),
              8'($random(seed)), r[7] | r[0]);
    end
    $display("test random stream done");
    // reset in mid-stream: pending work is dropped, not answered later
    drive(3'h5, 1'b1, 1'b1, 1'b1, 1'b0, 8'hff, 8'h11, 8'hff, 1'b1);
    @(negedge clk);
    arst_n = 1'b0;
    drive(3'h6, 1'b0, 1'b0, 1'b0, 1'b1, 8'h01, 8'h02, 8'h03, 1'b1);
    drive(3'h6, 1'b0, 1'b0, 1'b0, 1'b1, 8'h01, 8'h02, 8'h03, 1'b0);
    @(negedge clk);
    arst_n = 1'b1;
    drive(3'h6, 1'b0, 1'b1, 1'b0, 1'b1, 8'h7f, 8'h80, 8'h03, 1'b1);
    drive(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0);
    repeat (3) @(posedge clk);
    $display("test mid reset done");
    results();
end
endmodule : tb_operand_address_mode_resolver
`undef CHK
`default_nettype wire
